// *** logic/cid_map.vh ***
// Constants for the instruction decode block: opcodes, forms, state counts, flags
`ifndef CID_MAP_VH
`define CID_MAP_VH

// Opcode byte positions inside the first instruction word
`define CID_OP_MSB       15
`define CID_OP_LSB       8
`define CID_VARIANT_BIT  7

// Opcode values of the move family, the relative branches and the bit operations
`define CID_OP_MOVB_REG  8'h0c
`define CID_OP_MOVW_REG  8'h0d
`define CID_OP_MOVW_IMM  8'h79
`define CID_OP_MOV_IND   7'h34
`define CID_OP_MOV_INC   7'h36
`define CID_OP_MOV_DISP  7'h37
`define CID_OP_MOV_ABS16 7'h35
`define CID_NIB_MOVB_IMM 4'hf
`define CID_NIB_LD_ABS8  4'h2
`define CID_NIB_ST_ABS8  4'h3
`define CID_NIB_BRANCH   4'h4
`define CID_NIB_BITOP    5'h0e

// Operand forms
`define CID_FORM_NONE    3'h0
`define CID_FORM_IMM     3'h1
`define CID_FORM_REG     3'h2
`define CID_FORM_IND     3'h3
`define CID_FORM_DISP    3'h4
`define CID_FORM_INCDEC  3'h5
`define CID_FORM_ABS8    3'h6
`define CID_FORM_ABS16   3'h7

// Execution states per form
`define CID_ST_IMM8      3'h2
`define CID_ST_IMM16     3'h4
`define CID_ST_REG       3'h2
`define CID_ST_IND       3'h4
`define CID_ST_DISP      3'h6
`define CID_ST_INCDEC    3'h6
`define CID_ST_ABS8      3'h4
`define CID_ST_ABS16     3'h6
`define CID_ST_OTHER     3'h2

// Upper byte of an 8-bit absolute address
`define CID_ABS8_PAGE    8'hff

// Stack pointer register number
`define CID_SP_NUM       3'h7

// Flag bit positions and reset value
`define CID_FLAG_N       3
`define CID_FLAG_Z       2
`define CID_FLAG_V       1
`define CID_FLAG_C       0
`define CID_FLAGS_RST    4'h0

`endif

// *** logic/cid_regfile.v ***
// Eight 16-bit general registers with byte write enables and registered reads
`timescale 1ns/1ps
`default_nettype none
module cid_regfile
(
	// Clock
	input  wire        clock,
	input  wire        sys_rst,
	// Read ports
	input  wire [2:0]  rd_addr_a,
	input  wire [2:0]  rd_addr_b,
	output reg  [15:0] rd_data_a_ff,
	output reg  [15:0] rd_data_b_ff,
	// Write port
	input  wire        wr_en,
	input  wire [2:0]  wr_addr,
	input  wire [1:0]  wr_be,
	input  wire [15:0] wr_data
);

	reg [15:0] mem_ff [0:7];
	integer    i;

	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			for (i = 0; i < 8; i = i + 1)
				mem_ff[i] <= 16'h0000;
			rd_data_a_ff <= 16'h0000;
			rd_data_b_ff <= 16'h0000;
		end
		else
		begin
			if (wr_en && wr_be[1])
				mem_ff[wr_addr][15:8] <= wr_data[15:8];
			if (wr_en && wr_be[0])
				mem_ff[wr_addr][7:0] <= wr_data[7:0];
			rd_data_a_ff <= mem_ff[rd_addr_a];
			rd_data_b_ff <= mem_ff[rd_addr_b];
		end
	end

endmodule
`default_nettype wire

// *** logic/cid_decode.v ***
// Instruction decoder and move execution with condition flag update
// What this block does
// [RULE1] Opcode taken from bits 15..8 of word one
// [RULE2] Bit 7 picks between paired map entries
// [RULE3] Push and pop decode as SP moves
// [RULE4] Flag register holds N, Z, V, C
// [RULE5] Modified flags follow the actual result
// [RULE6] Unaffected flags keep their prior value
// [RULE7] Not-fixed flags may hold any value
// [RULE8] Registers used as 8 or 16 bits
// [RULE9] Immediates of 3, 8 or 16 bits
// [RULE10] Displacements of 8 or 16 bits added
// [RULE11] Absolute addresses of 8 or 16 bits
// [RULE12] Moves set N,Z, clear V, keep C
`timescale 1ns/1ps
`default_nettype none
`include "cid_map.vh"
module cid_decode
(
	// Clock and reset
	input  wire        clock,
	input  wire        sys_rst,
	// Instruction from fetch
	input  wire        insn_valid,
	input  wire [15:0] insn_word,
	input  wire [15:0] insn_ext,
	input  wire [15:0] insn_pc,
	output reg         insn_ready_ff,
	// Data memory
	output reg         mem_req_ff,
	output reg         mem_we_ff,
	output reg         mem_byte_ff,
	output reg  [15:0] mem_addr_ff,
	output reg  [15:0] mem_wdata_ff,
	input  wire [15:0] mem_rdata,
	// Decode results
	output reg  [7:0]  opcode_ff,
	output reg  [2:0]  form_ff,
	output reg  [15:0] imm_ff,
	output reg  [2:0]  imm3_ff,
	output reg         branch_ff,
	output reg  [15:0] branch_target_ff,
	output reg         done_ff,
	output reg  [3:0]  condition_flags_register
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	// Byte view of a register: numbers 0..7 upper halves, 8..15 lower halves
	function [7:0] get8;
		input [15:0] w;
		input        lo;
		begin
			get8 = lo ? w[7:0] : w[15:8];
		end
	endfunction

	function [15:0] sext8;
		input [7:0] b;
		begin
			sext8 = {{8{b[7]}}, b};
		end
	endfunction

	// Decoded fields of the offered instruction
	reg  [7:0]  op;
	reg         var_bit;
	reg  [2:0]  nxt_form;
	reg         nxt_store;
	reg         nxt_byte;
	reg  [3:0]  nxt_dreg;
	reg  [2:0]  nxt_preg;
	reg  [15:0] nxt_imm;
	reg  [2:0]  nxt_states;
	reg         nxt_branch;

	always @*
	begin
		op         = insn_word[`CID_OP_MSB:`CID_OP_LSB]; // RULE1
		var_bit    = insn_word[`CID_VARIANT_BIT];
		nxt_form   = `CID_FORM_NONE;
		nxt_store  = 1'b0;
		nxt_byte   = 1'b1;
		nxt_dreg   = insn_word[3:0];
		nxt_preg   = insn_word[6:4];
		nxt_imm    = 16'h0000;
		nxt_states = `CID_ST_OTHER;
		nxt_branch = 1'b0;
		if (op == `CID_OP_MOVB_REG || op == `CID_OP_MOVW_REG)
		begin
			nxt_form   = `CID_FORM_REG;
			nxt_byte   = ~op[0]; // RULE8
			nxt_preg   = op[0] ? insn_word[6:4] : insn_word[6:4];
			nxt_states = `CID_ST_REG;
		end
		else if (op[7:4] == `CID_NIB_MOVB_IMM)
		begin
			nxt_form   = `CID_FORM_IMM;
			nxt_dreg   = op[3:0];
			nxt_imm    = {8'h00, insn_word[7:0]}; // RULE9
			nxt_states = `CID_ST_IMM8;
		end
		else if (op == `CID_OP_MOVW_IMM)
		begin
			nxt_form   = `CID_FORM_IMM;
			nxt_byte   = 1'b0;
			nxt_imm    = insn_ext; // RULE9
			nxt_states = `CID_ST_IMM16;
		end
		else if (op[7:4] == `CID_NIB_LD_ABS8 || op[7:4] == `CID_NIB_ST_ABS8)
		begin
			nxt_form   = `CID_FORM_ABS8;
			nxt_store  = op[4];
			nxt_dreg   = op[3:0];
			nxt_imm    = {`CID_ABS8_PAGE, insn_word[7:0]}; // RULE11
			nxt_states = `CID_ST_ABS8;
		end
		else if (op[7:1] == `CID_OP_MOV_IND)
		begin
			nxt_form   = `CID_FORM_IND;
			nxt_store  = var_bit; // RULE2
			nxt_byte   = ~op[0];
			nxt_states = `CID_ST_IND;
		end
		else if (op[7:1] == `CID_OP_MOV_DISP)
		begin
			nxt_form   = `CID_FORM_DISP;
			nxt_store  = var_bit; // RULE2
			nxt_byte   = ~op[0];
			nxt_imm    = insn_ext; // RULE10
			nxt_states = `CID_ST_DISP;
		end
		else if (op[7:1] == `CID_OP_MOV_INC)
		begin
			// Push and pop are these forms with the stack pointer as pointer
			nxt_form   = `CID_FORM_INCDEC; // RULE3
			nxt_store  = var_bit; // RULE2
			nxt_byte   = ~op[0];
			nxt_states = `CID_ST_INCDEC;
		end
		else if (op[7:1] == `CID_OP_MOV_ABS16)
		begin
			nxt_form   = `CID_FORM_ABS16;
			nxt_store  = var_bit; // RULE2
			nxt_byte   = ~op[0];
			nxt_imm    = insn_ext; // RULE11
			nxt_states = `CID_ST_ABS16;
		end
		else if (op[7:4] == `CID_NIB_BRANCH)
		begin
			nxt_branch = 1'b1;
			nxt_imm    = sext8(insn_word[7:0]); // RULE10
		end
	end

	// Register file; reads arrive one cycle after the instruction is taken
	wire [15:0] ra_data;
	wire [15:0] rb_data;
	reg         wr_en;
	reg  [2:0]  wr_addr;
	reg  [1:0]  wr_be;
	reg  [15:0] wr_data;

	cid_regfile u_regs
	(
		.clock        (clock),
		.sys_rst      (sys_rst),
		.rd_addr_a    (nxt_preg),
		.rd_addr_b    (nxt_dreg[2:0]),
		.rd_data_a_ff (ra_data),
		.rd_data_b_ff (rb_data),
		.wr_en        (wr_en),
		.wr_addr      (wr_addr),
		.wr_be        (wr_be),
		.wr_data      (wr_data)
	);

	reg         state_ff;
	reg         first_ff;
	reg  [2:0]  cnt_ff;
	reg         store_ff;
	reg         byte_ff;
	reg  [3:0]  dreg_ff;
	reg  [3:0]  sreg_ff;

	// Effective address and operand values, valid in the first execute cycle
	reg  [15:0] ea_c;
	reg  [15:0] src_c;
	reg  [15:0] step_c;
	reg  [15:0] val_c;
	reg         last_c;

	always @*
	begin
		step_c = byte_ff ? 16'h0001 : 16'h0002;
		src_c  = byte_ff ? {8'h00, get8(rb_data, dreg_ff[3])} : rb_data; // RULE8
		case (form_ff)
			`CID_FORM_IND:    ea_c = ra_data;
			`CID_FORM_DISP:   ea_c = ra_data + imm_ff; // RULE10
			`CID_FORM_INCDEC: ea_c = store_ff ? ra_data - step_c : ra_data; // RULE3
			`CID_FORM_ABS8:   ea_c = imm_ff; // RULE11
			`CID_FORM_ABS16:  ea_c = imm_ff; // RULE11
			default:          ea_c = 16'h0000;
		endcase
		last_c = (state_ff == ST_EXEC) && (cnt_ff == 3'h0);
		case (form_ff)
			`CID_FORM_IMM: val_c = imm_ff;
			`CID_FORM_REG: val_c = byte_ff ? {8'h00, get8(ra_data, sreg_ff[3])} : ra_data;
			default:       val_c = store_ff ? mem_wdata_ff : mem_rdata;
		endcase
		if (byte_ff)
			val_c = {8'h00, val_c[7:0]};
	end

	// Writes: pointer step in the first cycle, loaded value in the last
	always @*
	begin
		wr_en   = 1'b0;
		wr_addr = dreg_ff[2:0];
		wr_be   = 2'b11;
		wr_data = val_c;
		if (state_ff == ST_EXEC && first_ff && form_ff == `CID_FORM_INCDEC)
		begin
			wr_en   = 1'b1;
			wr_addr = sreg_ff[2:0];
			wr_data = store_ff ? ea_c : ra_data + step_c; // RULE3
		end
		else if (last_c && !store_ff && form_ff != `CID_FORM_NONE)
		begin
			wr_en   = 1'b1;
			wr_be   = byte_ff ? (dreg_ff[3] ? 2'b01 : 2'b10) : 2'b11; // RULE8
			wr_data = byte_ff ? {val_c[7:0], val_c[7:0]} : val_c;
		end
	end

	wire mem_form = (form_ff != `CID_FORM_NONE) && (form_ff != `CID_FORM_IMM)
		&& (form_ff != `CID_FORM_REG);

	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_ff                 <= ST_IDLE;
			first_ff                 <= 1'b0;
			cnt_ff                   <= 3'h0;
			store_ff                 <= 1'b0;
			byte_ff                  <= 1'b1;
			dreg_ff                  <= 4'h0;
			sreg_ff                  <= 4'h0;
			insn_ready_ff            <= 1'b0;
			mem_req_ff               <= 1'b0;
			mem_we_ff                <= 1'b0;
			mem_byte_ff              <= 1'b0;
			mem_addr_ff              <= 16'h0000;
			mem_wdata_ff             <= 16'h0000;
			opcode_ff                <= 8'h00;
			form_ff                  <= `CID_FORM_NONE;
			imm_ff                   <= 16'h0000;
			imm3_ff                  <= 3'h0;
			branch_ff                <= 1'b0;
			branch_target_ff         <= 16'h0000;
			done_ff                  <= 1'b0;
			condition_flags_register <= `CID_FLAGS_RST;
		end
		else
		begin
			done_ff   <= 1'b0;
			branch_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
				begin
					insn_ready_ff <= 1'b1;
					if (insn_valid && insn_ready_ff)
					begin
						state_ff      <= ST_EXEC;
						first_ff      <= 1'b1;
						insn_ready_ff <= 1'b0;
						cnt_ff        <= nxt_states - 3'h2;
						opcode_ff     <= op;
						form_ff       <= nxt_form;
						store_ff      <= nxt_store;
						byte_ff       <= nxt_byte;
						dreg_ff       <= nxt_dreg;
						sreg_ff       <= {insn_word[7], nxt_preg};
						imm_ff        <= nxt_imm;
						imm3_ff       <= insn_word[6:4]; // RULE9
						branch_ff     <= nxt_branch;
						branch_target_ff <= insn_pc + sext8(insn_word[7:0]); // RULE10
					end
				end
				ST_EXEC:
				begin
					first_ff <= 1'b0;
					if (first_ff && mem_form && !last_c)
					begin
						mem_req_ff   <= 1'b1;
						mem_we_ff    <= store_ff;
						mem_byte_ff  <= byte_ff;
						mem_addr_ff  <= ea_c;
						mem_wdata_ff <= src_c;
					end
					if (last_c)
					begin
						state_ff      <= ST_IDLE;
						insn_ready_ff <= 1'b1;
						mem_req_ff    <= 1'b0;
						mem_we_ff     <= 1'b0;
						done_ff       <= 1'b1;
						// Moves: N and Z from the moved value, V cleared, C kept
						if (form_ff != `CID_FORM_NONE)
						begin
							condition_flags_register[`CID_FLAG_N] <=
								byte_ff ? val_c[7] : val_c[15]; // RULE5 RULE12
							condition_flags_register[`CID_FLAG_Z] <=
								(val_c == 16'h0000); // RULE5 RULE12
							condition_flags_register[`CID_FLAG_V] <= 1'b0; // RULE12
						end
						// Carry is never written here; other opcodes leave all four flags
					end // RULE4 RULE6 RULE7
					else
						cnt_ff <= cnt_ff - 3'h1;
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** test/cid_decode_sva.sv ***
// Port assertions for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "cid_map.vh"
module cid_decode_sva
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// Instruction side
	input wire logic        insn_valid,
	input wire logic [15:0] insn_word,
	input wire logic [15:0] insn_pc,
	input wire logic        insn_ready_ff,
	// Results
	input wire logic        mem_req_ff,
	input wire logic [15:0] mem_addr_ff,
	input wire logic [7:0]  opcode_ff,
	input wire logic [2:0]  form_ff,
	input wire logic [15:0] imm_ff,
	input wire logic        branch_ff,
	input wire logic [15:0] branch_target_ff,
	input wire logic        done_ff,
	input wire logic [3:0]  condition_flags_register
);
	logic [15:0] exp_target_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	always @(posedge clock)
		exp_target_ff <= insn_pc + {{8{insn_word[7]}}, insn_word[7:0]};

	sequence s_take;
		insn_valid && insn_ready_ff;
	endsequence
	sequence s_finish;
		##[0:5] (done_ff && insn_ready_ff);
	endsequence

	a_done_bound: assert property (s_take |=> s_finish)
		else $error("done not seen within six states");
	// Ready comes back on its own two edges after a reset, not with done
	a_ready_done: assert property ($rose(insn_ready_ff) && !$past(sys_rst, 2) |-> done_ff)
		else $error("ready rose without done");
	a_done_pulse: assert property (done_ff |=> !done_ff)
		else $error("done longer than one cycle");
	a_opcode_byte: assert property (s_take |=> {opcode_ff, 8'h00} == ($past(insn_word) & 16'hff00))
		else $error("opcode not from upper byte");
	a_flags_quiet: assert property (!done_ff && !$past(sys_rst) |-> $stable(condition_flags_register))
		else $error("flags changed outside done");
	a_carry_kept: assert property ($stable(condition_flags_register[`CID_FLAG_C]))
		else $error("carry flag changed");
	a_v_cleared: assert property (done_ff && form_ff != `CID_FORM_NONE
		|-> !condition_flags_register[`CID_FLAG_V])
		else $error("overflow not cleared by move");
	a_imm_flags: assert property (done_ff && opcode_ff == `CID_OP_MOVW_IMM
		|-> condition_flags_register[3:2] == {imm_ff[15], imm_ff == 16'h0000})
		else $error("flags differ from immediate");
	a_branch_calc: assert property (s_take and (insn_word[15:12] == `CID_NIB_BRANCH)
		|=> branch_ff && branch_target_ff == exp_target_ff)
		else $error("branch target wrong");
	a_abs8_page: assert property (mem_req_ff && form_ff == `CID_FORM_ABS8
		|-> mem_addr_ff[15:8] == `CID_ABS8_PAGE)
		else $error("short address page wrong");
	a_addr_hold: assert property (mem_req_ff && $past(mem_req_ff) |-> $stable(mem_addr_ff))
		else $error("address moved during access");
endmodule

bind cid_decode cid_decode_sva i_sva (.clock, .sys_rst, .insn_valid, .insn_word, .insn_pc,
	.insn_ready_ff, .mem_req_ff, .mem_addr_ff, .opcode_ff, .form_ff, .imm_ff, .branch_ff,
	.branch_target_ff, .done_ff, .condition_flags_register);
`default_nettype wire

// *** test/test_cid_decode.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
$display("[ERR] %s exp %h got %h", n, e, a); end end
module test_cid_decode;
	typedef struct {logic [15:0] w, x, rd; logic [2:0] f, n; logic [3:0] fl;
		logic [15:0] a, wd; logic e;} cid_row_t;
	logic        clock, sys_rst, insn_valid;
	logic [15:0] insn_word, insn_ext, insn_pc, mem_rdata;
	wire         insn_ready_ff, mem_req_ff, mem_we_ff, mem_byte_ff, branch_ff, done_ff;
	wire  [15:0] mem_addr_ff, mem_wdata_ff, imm_ff, branch_target_ff;
	wire  [7:0]  opcode_ff;
	wire  [2:0]  form_ff, imm3_ff;
	wire  [3:0]  condition_flags_register;
	int          mismatches, tests_run, cycles;
	cid_row_t    rows [13] = '{
		'{16'hf880, 16'h0, 16'h0, 3'h1, 3'h2, 4'h8, 16'h0, 16'h0, 1'h0},
		'{16'hf000, 16'h0, 16'h0, 3'h1, 3'h2, 4'h4, 16'h0, 16'h0, 1'h0},
		'{16'h7901, 16'h8000, 16'h0, 3'h1, 3'h4, 4'h8, 16'h0, 16'h0, 1'h0},
		'{16'h40fe, 16'h0100, 16'h0, 3'h0, 3'h2, 4'h8, 16'h0, 16'h0, 1'h0},
		'{16'h0d12, 16'h0, 16'h0, 3'h2, 3'h2, 4'h8, 16'h0, 16'h0, 1'h0},
		'{16'h0c0b, 16'h0, 16'h0, 3'h2, 3'h2, 4'h4, 16'h0, 16'h0, 1'h0},
		'{16'h7050, 16'h0, 16'h0, 3'h0, 3'h2, 4'h4, 16'h0, 16'h0, 1'h0},
		'{16'h2812, 16'h0, 16'h0055, 3'h6, 3'h4, 4'h0, 16'hff12, 16'h0, 1'h0},
		'{16'h3834, 16'h0, 16'h0, 3'h6, 3'h4, 4'h0, 16'hff34, 16'h0055, 1'h1},
		'{16'h6df1, 16'h0, 16'h0, 3'h5, 3'h6, 4'h8, 16'hfffe, 16'h8000, 1'h1},
		'{16'h6d73, 16'h0, 16'h0001, 3'h5, 3'h6, 4'h0, 16'hfffe, 16'h0, 1'h0},
		'{16'h6fa1, 16'h0010, 16'h0, 3'h4, 3'h6, 4'h8, 16'h8010, 16'h8000, 1'h1},
		'{16'h6812, 16'h0, 16'h0080, 3'h3, 3'h4, 4'h8, 16'h8000, 16'h0, 1'h0}};

	cid_decode i_dut (.clock, .sys_rst, .insn_valid, .insn_word, .insn_ext, .insn_pc,
		.insn_ready_ff, .mem_req_ff, .mem_we_ff, .mem_byte_ff, .mem_addr_ff,
		.mem_wdata_ff, .mem_rdata, .opcode_ff, .form_ff, .imm_ff, .imm3_ff, .branch_ff,
		.branch_target_ff, .done_ff, .condition_flags_register);

	initial
	begin
		clock = 0;
		forever #5 clock = ~clock;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Hang guard, well above the 80 or so cycles the run needs
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	// Sample 1 ns after each edge so that edge's updates have landed
	task automatic run(input cid_row_t r);
		int          n;
		logic [15:0] a, wd, bt;
		logic        e, br, by;
		a = 0;
		wd = 0;
		e = 0;
		by = 0;
		n = 1;
		@(posedge clock);
		insn_valid <= 1;
		insn_word <= r.w;
		insn_ext <= r.x;
		insn_pc <= r.x;
		mem_rdata <= r.rd;
		@(posedge clock);
		insn_valid <= 0;
		#1 br = branch_ff;
		bt = branch_target_ff;
		`CHK("opcode", r.w[15:8], opcode_ff)
		`CHK("form", r.f, form_ff)
		`CHK("imm3", r.w[6:4], imm3_ff)
		while (done_ff !== 1'b1 && n < 9)
		begin
			@(posedge clock);
			#1 n++;
			if (mem_req_ff)
			begin
				a = mem_addr_ff;
				e = mem_we_ff;
				by = mem_byte_ff;
				// Store data means nothing on a load
				if (mem_we_ff)
					wd = mem_wdata_ff;
			end
		end
		`CHK("states", r.n, n[2:0])
		`CHK("flags", r.fl, condition_flags_register)
		`CHK("addr", r.a, a)
		`CHK("wdata", r.wd, wd)
		`CHK("store", r.e, e)
		`CHK("byte", (r.f == 3'h6) || (r.f > 3'h2 && !r.w[8]), by)
		`CHK("branch", r.w[15:12] == 4'h4, br)
		if (br)
			`CHK("target", r.x + {{8{r.w[7]}}, r.w[7:0]}, bt)
	endtask

	initial
	begin
		sys_rst = 1;
		insn_valid = 0;
		insn_word = 16'h0;
		insn_ext = 16'h0;
		insn_pc = 16'h0;
		mem_rdata = 16'h0;
		repeat (3) @(posedge clock);
		sys_rst <= 0;
		@(posedge clock);
		#1 `CHK("ready", 1'h1, insn_ready_ff)
		foreach (rows[i])
			run(rows[i]);
		// A request offered while busy must be ignored
		fork
			run('{16'h6b83, 16'h1234, 16'h0, 3'h7, 3'h6, 4'h0, 16'h1234, 16'h0001, 1'h1});
			begin
				repeat (4) @(posedge clock);
				insn_valid <= 1;
				insn_word <= 16'hf8ff;
				@(posedge clock);
				insn_valid <= 0;
			end
		join
		`CHK("refused", 8'h6b, opcode_ff)
		// Leave flags set so the reset below has something to clear
		run('{16'hf880, 16'h0, 16'h0, 3'h1, 3'h2, 4'h8, 16'h0, 16'h0, 1'h0});
		@(posedge clock);
		insn_valid <= 1;
		insn_word <= 16'h7901;
		@(posedge clock);
		insn_valid <= 0;
		sys_rst <= 1;
		@(posedge clock);
		sys_rst <= 0;
		#1 `CHK("rst_flags", 4'h0, condition_flags_register)
		`CHK("rst_ready", 1'h0, insn_ready_ff)
		run('{16'h0c80, 16'h0, 16'h0, 3'h2, 3'h2, 4'h4, 16'h0, 16'h0, 1'h0});
		report_and_stop();
	end
endmodule
`default_nettype wire
